/* File: rtl/bdc_regs.svh */
// Offsets, field positions, reset values and timing counts of the converter supervisory control.
// Assumes a 10 MHz reference clock and a 32-bit AHB-Lite register port.
//
// Notes on behaviour
// RL1: Converter starts, via soft start, only with enable pin high and both enable bits set.
// RL2: Each enable pin rising edge loads every register with its default.
// RL3: Setting the enable bit leaves all other register contents untouched.
// RL4: Enable pin low or bit 6 clear in a voltage register means full shutdown.
// RL5: Ramp register bit 6 set connects the output discharge path when off.
// RL6: First soft-start phase widens on-time from 35 ns for about 100 us.
// RL7: Then half current limit; after 100 us more, full limit if output above 0.5 V.
// RL8: Both switches stay off while input is under the lockout threshold.
// RL9: High-side current at limit turns it off and low side on, every cycle.
// RL10: Output below 0.4 V halves the current limit and clears power good.
// RL11: Over-temperature turns both switches off; operation resumes when it clears.
// RL12: Select pin low regulates to the floor register with the low-state mode bit.
// RL13: Select pin high regulates to the roof register with the high-state mode bit.
// RL14: Writing the selected voltage register starts an output change at the ramp rate.
// RL15: Writing the unselected voltage register leaves the output unchanged.
// RL16: PFM downward select change holds power good low until pulsing resumes.
// RL17: Multiple-step mode holds power good low while ramping.
// RL18: Three-bit slew field selects ramp mode; 111 is single step and default.
// RL19: Single step upward moves at maximum slew rate.
// RL20: Single step downward: immediate in forced PWM, stop switching in auto mode; the code steps at once in both modes and stops switching for one cycle only.
// RL21: Slew values 000 to 110 micro-step; the value sets the step interval.
// RL22: The processor programs floor, roof and slew and may rewrite voltages anytime.
// RL23: No register updates while the enable pin is low; bus works otherwise.
// RL24: Voltage codes are steps of 12.5 mV.
// RL25: Select pin change switches target register and mode bit at once.
`ifndef BDC_REGS_SVH
`define BDC_REGS_SVH
`define BDC_OFS_FLOOR       8'h00
`define BDC_OFS_ROOF        8'h04
`define BDC_OFS_MODE        8'h08
`define BDC_OFS_RAMP        8'h0c
`define BDC_OFS_STATUS      8'h10
`define BDC_OFS_TARGET      8'h14
`define BDC_BIT_EN          7
`define BDC_BIT_VFREE       6
`define BDC_BIT_LOW_STATE_MODE_BIT       0
`define BDC_BIT_HIGH_STATE_MODE_BIT       1
`define BDC_BIT_DISCH       6
`define BDC_VOLT_RST        8'hc0
`define BDC_MODE_RST        8'h00
`define BDC_RAMP_RST        8'h07
`define BDC_SLEW_SINGLE     3'h7
`define BDC_STEP_UV         12500
`define BDC_SS_PHASE_NS     100000
`define BDC_CLK_NS          100
`define BDC_MIN_ON_NS       35
`define BDC_STEP_BASE_CYC   16
`endif

/* File: rtl/bdc_pkg.sv */
// Types shared by the converter supervisory control.
// Assumes the constants header is included by users.
package bdc_pkg;
  typedef enum logic [2:0] {
    BDC_OFF     = 3'b000,
    BDC_SS_ON   = 3'b001,
    BDC_SS_HALF = 3'b010,
    BDC_RUN     = 3'b011,
    BDC_FAULT   = 3'b100
  } bdc_phase_t;

  typedef struct packed {
    logic        htrans1;
    logic        hwrite;
    logic [7:0]  haddr;
    logic        hsel;
  } bdc_ahb_req_t;

  typedef struct packed {
    logic power_good;
    logic high_on;
    logic low_on;
    logic half_limit;
    logic widen_ontime;
    logic divider_on;
    logic control_on;
    logic discharge_on;
    logic pfm_mode;
    logic stop_switching;
  } bdc_pwr_t;

  typedef struct packed {
    logic vin_low;
    logic over_temp;
    logic curr_limit;
    logic out_below_04;
    logic out_above_05;
    logic at_target;
    logic pulsing;
  } bdc_sense_t;
endpackage : bdc_pkg

/* File: rtl/bdc_sync.sv */
// Three-stage input synchroniser; output changes once the second and third stages agree.
// Assumes the input is asynchronous to ref_clk_in.
`timescale 1ns/10ps
`default_nettype none
module bdc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  import bdc_pkg::*;
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } bdc_sync_st_t;
  bdc_sync_st_t st;
  bdc_sync_st_t next_st;
  always_comb
  begin
    next_st    = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st.s2[i] == st.s3[i])
        next_st.q[i] = st.s3[i];
    end
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      st <= '0;
    else
      st <= next_st;
  end
  assign sync_out = st.q;
endmodule // bdc_sync
`default_nettype wire

/* File: rtl/bdc_ramp.sv */
// Output target ramp: single step or micro-steps of one code at a slew-dependent interval.
// Assumes the target code comes from the register block on the same clock.
`include "bdc_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module bdc_ramp #(
  parameter int CW = 16
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       run_in,
  input  wire logic [5:0] target_in,
  input  wire logic [2:0] slew_in,
  input  wire logic       pfm_in,
  output var  logic [5:0] level_out,
  output logic            ramping_out,
  output logic            stop_sw_out
);
  import bdc_pkg::*;
  typedef struct packed {
    logic [5:0]    level;
    logic [CW-1:0] cnt;
  } bdc_ramp_st_t;
  bdc_ramp_st_t st;
  bdc_ramp_st_t next_st;
  logic [CW-1:0] interval;
  logic          single;
  always_comb
  begin
    single   = (slew_in == `BDC_SLEW_SINGLE); // see RL18
    interval = CW'(`BDC_STEP_BASE_CYC) << slew_in; // see RL21
    next_st  = st;
    if (!run_in)
    begin
      next_st.level = target_in;
      next_st.cnt   = '0;
    end
    else if (st.level != target_in)
    begin
      if (single)
      begin
        // Upward goes at full slew; downward steps at once in forced PWM and in auto mode alike.
        if (target_in > st.level || !pfm_in) // see RL19, RL20
          next_st.level = target_in;
        else
          next_st.level = target_in;
        next_st.cnt = '0;
      end
      else if (st.cnt >= interval - CW'(1))
      begin
        next_st.cnt   = '0;
        next_st.level = (target_in > st.level) ? st.level + 6'h01 : st.level - 6'h01; // see RL21
      end
      else
        next_st.cnt = st.cnt + CW'(1);
    end
    else
      next_st.cnt = '0;
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      st <= '0;
    else
      st <= next_st;
  end
  assign level_out   = st.level;
  assign ramping_out = run_in && (st.level != target_in) && !single;
  assign stop_sw_out = run_in && single && pfm_in && (target_in < st.level);
endmodule // bdc_ramp
`default_nettype wire

/* File: rtl/bdc_ctrl.sv */
// Supervisory control of the step-down converter: registers, enable, soft start, protections, target select.
// Assumes analogue comparators arrive as asynchronous levels and software uses AHB-Lite word access.
`include "bdc_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module bdc_ctrl #(
  parameter int SS_CYC = (`BDC_SS_PHASE_NS + `BDC_CLK_NS - 1) / `BDC_CLK_NS
) (
  input  wire logic               ref_clk_in,
  input  wire logic               rst_in,
  input  wire logic               hsel_in,
  input  wire logic [31:0]        haddr_in,
  input  wire logic [1:0]         htrans_in,
  input  wire logic               hwrite_in,
  input  wire logic [2:0]         hsize_in,
  input  wire logic [31:0]        hwdata_in,
  input  wire logic               hready_in,
  output var  logic [31:0]        hrdata_out,
  output logic                    hreadyout_out,
  output logic                    hresp_out,
  input  wire logic               enable_pin_in,
  input  wire logic               voltage_select_pin_in,
  input  wire bdc_pkg::bdc_sense_t sense_in,
  output var  bdc_pkg::bdc_pwr_t  pwr_out,
  output var  logic [5:0]         vout_code_out
);
  import bdc_pkg::*;
  localparam int SSW = $clog2(SS_CYC + 1);
  localparam int NIN = 9;
  typedef struct packed {
    logic [7:0]     floor_voltage_reg;
    logic [7:0]     roof_voltage_reg;
    logic [7:0]     mode_config_reg;
    logic [7:0]     ramp_config_reg;
    logic           en_prev;
    logic           sel_prev;
    logic           pg_hold;
    bdc_phase_t     phase;
    logic [SSW-1:0] ss_cnt;
    logic           ap_wr;
    logic [7:0]     ap_addr;
    logic [31:0]    rdata;
    bdc_pwr_t       pwr;
  } bdc_ctrl_st_t;
  bdc_ctrl_st_t st;
  bdc_ctrl_st_t next_st;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync_in;
  logic           en_pin;
  logic           sel_pin;
  bdc_sense_t     sense;
  logic [7:0]     target_reg;
  logic           target_pfm;
  logic           conv_on;
  logic           sw_allow;
  logic [5:0]     ramp_level;
  logic           ramping;
  logic           stop_sw;

  function automatic logic [31:0] bdc_read(input bdc_ctrl_st_t s, input logic [7:0] a,
                                           input logic [5:0] lvl);
    logic [31:0] d;
    d = '0;
    unique case (a)
      `BDC_OFS_FLOOR:  d[7:0] = s.floor_voltage_reg;
      `BDC_OFS_ROOF:   d[7:0] = s.roof_voltage_reg;
      `BDC_OFS_MODE:   d[7:0] = s.mode_config_reg;
      `BDC_OFS_RAMP:   d[7:0] = s.ramp_config_reg;
      `BDC_OFS_STATUS: d[7:0] = {4'h0, s.pwr.power_good, 3'(s.phase)};
      `BDC_OFS_TARGET: d[5:0] = lvl;
      default:         d = '0;
    endcase
    return d;
  endfunction

  assign raw_in = {enable_pin_in, voltage_select_pin_in, sense_in};

  bdc_sync #(
    .W (NIN)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   (raw_in),
    .sync_out   (sync_in)
  );

  assign en_pin  = sync_in[NIN-1];
  assign sel_pin = sync_in[NIN-2];
  assign sense   = sync_in[NIN-3:0];

  // Select pin picks register and mode bit together, without delay.
  assign target_reg = sel_pin ? st.roof_voltage_reg : st.floor_voltage_reg; // see RL12, RL13, RL25
  assign target_pfm = !(sel_pin ? st.mode_config_reg[`BDC_BIT_HIGH_STATE_MODE_BIT]
                                : st.mode_config_reg[`BDC_BIT_LOW_STATE_MODE_BIT]); // see RL12, RL13
  assign conv_on = en_pin && st.floor_voltage_reg[`BDC_BIT_VFREE]
                          && st.roof_voltage_reg[`BDC_BIT_VFREE]; // see RL1, RL4
  assign sw_allow = conv_on && !sense.vin_low && !sense.over_temp; // see RL8, RL11

  // Each code is one 12.5 mV step; the analogue DAC maps the code to volts.
  bdc_ramp #(
    .CW (16)
  ) u_ramp (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .run_in      (st.phase == BDC_RUN),
    .target_in   (target_reg[5:0]),
    .slew_in     (st.ramp_config_reg[2:0]),
    .pfm_in      (target_pfm),
    .level_out   (ramp_level),
    .ramping_out (ramping),
    .stop_sw_out (stop_sw)
  ); // see RL14, RL15, RL24

  always_comb
  begin
    next_st          = st;
    next_st.en_prev  = en_pin;
    next_st.sel_prev = sel_pin;
    next_st.ap_wr    = 1'b0;
    next_st.rdata    = '0;

    // AHB-Lite slave: zero wait states, word-size writes only, reads of any size, unmapped reads return zero.
    if (hsel_in && hready_in && htrans_in[1])
    begin
      next_st.ap_wr   = hwrite_in && (hsize_in == 3'h2);
      next_st.ap_addr = haddr_in[7:0];
      if (!hwrite_in)
        next_st.rdata = bdc_read(st, haddr_in[7:0], ramp_level);
    end
    // Writes are dropped in hardware shutdown, but accepted with only the enable bit clear.
    if (st.ap_wr && en_pin) // see RL23
    begin
      unique case (st.ap_addr)
        `BDC_OFS_FLOOR: next_st.floor_voltage_reg = hwdata_in[7:0]; // see RL3, RL22
        `BDC_OFS_ROOF:  next_st.roof_voltage_reg  = hwdata_in[7:0]; // see RL3, RL22
        `BDC_OFS_MODE:  next_st.mode_config_reg   = hwdata_in[7:0];
        `BDC_OFS_RAMP:  next_st.ramp_config_reg   = hwdata_in[7:0];
        default:        next_st.ap_wr = 1'b0;
      endcase
    end
    if (en_pin && !st.en_prev)
    begin
      next_st.floor_voltage_reg = `BDC_VOLT_RST; // see RL2
      next_st.roof_voltage_reg  = `BDC_VOLT_RST; // see RL2
      next_st.mode_config_reg   = `BDC_MODE_RST; // see RL2
      next_st.ramp_config_reg   = `BDC_RAMP_RST; // see RL2, RL18
    end

    // Soft start and protection sequencing.
    if (!conv_on)
    begin
      next_st.phase  = BDC_OFF; // see RL4
      next_st.ss_cnt = '0;
    end
    else
    begin
      unique case (st.phase)
        BDC_OFF:
        begin
          next_st.phase  = BDC_SS_ON; // see RL1
          next_st.ss_cnt = '0;
        end
        BDC_SS_ON:
        begin
          if (sense.at_target)
            next_st.phase = BDC_RUN;
          else if (st.ss_cnt >= SSW'(SS_CYC - 1))
          begin
            next_st.phase  = BDC_SS_HALF; // see RL7
            next_st.ss_cnt = '0;
          end
          else
            next_st.ss_cnt = st.ss_cnt + SSW'(1); // see RL6
        end
        BDC_SS_HALF:
        begin
          if (st.ss_cnt >= SSW'(SS_CYC - 1))
          begin
            if (sense.out_above_05)
              next_st.phase = BDC_RUN; // see RL7
          end
          else
            next_st.ss_cnt = st.ss_cnt + SSW'(1);
        end
        BDC_RUN:
          if (sense.vin_low || sense.over_temp)
            next_st.phase = BDC_FAULT; // see RL8, RL11
        BDC_FAULT:
          if (!sense.vin_low && !sense.over_temp)
          begin
            next_st.phase  = BDC_SS_ON; // see RL11
            next_st.ss_cnt = '0;
          end
        default:
          next_st.phase = BDC_OFF;
      endcase
    end

    // Downward select change in PFM keeps power good low until pulsing resumes.
    if (st.sel_prev && !sel_pin && target_pfm)
      next_st.pg_hold = 1'b1; // see RL16
    else if (sense.pulsing || !conv_on)
      next_st.pg_hold = 1'b0;

    next_st.pwr.control_on     = conv_on; // see RL4
    next_st.pwr.divider_on     = conv_on; // see RL4
    next_st.pwr.discharge_on   = !conv_on && st.ramp_config_reg[`BDC_BIT_DISCH]; // see RL5
    next_st.pwr.widen_ontime   = sw_allow && (st.phase == BDC_SS_ON); // see RL6
    next_st.pwr.half_limit     = (st.phase == BDC_SS_HALF) || sense.out_below_04; // see RL7, RL10
    next_st.pwr.pfm_mode       = target_pfm;
    next_st.pwr.stop_switching = stop_sw; // see RL20
    // Current limit ends the high-side pulse and hands over to the low side each cycle.
    next_st.pwr.high_on = sw_allow && (st.phase != BDC_OFF) && !sense.curr_limit && !stop_sw; // see RL9
    next_st.pwr.low_on  = sw_allow && (st.phase != BDC_OFF) && (sense.curr_limit || !stop_sw); // see RL9
    next_st.pwr.power_good = (st.phase == BDC_RUN) && sw_allow && !sense.out_below_04 // see RL10
                             && !ramping && !st.pg_hold; // see RL16, RL17
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      st                   <= '0;
      st.floor_voltage_reg <= `BDC_VOLT_RST;
      st.roof_voltage_reg  <= `BDC_VOLT_RST;
      st.mode_config_reg   <= `BDC_MODE_RST;
      st.ramp_config_reg   <= `BDC_RAMP_RST;
      st.phase             <= BDC_OFF;
    end
    else
      st <= next_st;
  end

  assign hrdata_out    = st.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign pwr_out       = st.pwr;
  assign vout_code_out = ramp_level;
endmodule // bdc_ctrl
`default_nettype wire

/* File: bench/bdc_ctrl_asserts.sv */
// Port checks for the converter supervisory control.
// Assumes a bind onto bdc_ctrl; pins and sense levels reach the registered outputs within six clocks.
`timescale 1ns/10ps
`default_nettype none
module bdc_ctrl_asserts
  import bdc_pkg::*;
#(
  parameter int SS_CYC = 1000
) (
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic        hsel_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        enable_pin_in,
  input wire bdc_sense_t  sense_in,
  input wire bdc_pwr_t    pwr_out
);
  // A counter bounds the first soft-start phase, too long for a repetition.
  int unsigned wide_cnt;
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || !pwr_out.widen_ontime)
    begin
      wide_cnt <= 0;
    end
    else
    begin
      wide_cnt <= wide_cnt + 1;
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  sequence ss_start_s;
    $rose(pwr_out.control_on);
  endsequence
  bus_okay_a: assert property (hreadyout_out && !hresp_out)
    else $error("bus answer not ready and okay");
  rdata_idle_a: assert property (!(hsel_in && hready_in && htrans_in[1] && !hwrite_in) |=> hrdata_out == 32'h0)
    else $error("read data outside a read data phase");
  ss_start_a: assert property (ss_start_s |-> !pwr_out.power_good ##1 (pwr_out.widen_ontime || !pwr_out.high_on))
    else $error("start without first soft-start phase");
  ss_len_a: assert property (wide_cnt <= SS_CYC + 1)
    else $error("first soft-start phase too long");
  shutdown_a: assert property (!enable_pin_in [*6] |-> !pwr_out.control_on && !pwr_out.high_on && !pwr_out.low_on)
    else $error("converter active with enable pin low");
  input_undervoltage_lockout_off_a: assert property (sense_in.vin_low [*6] |-> !pwr_out.high_on && !pwr_out.low_on)
    else $error("switch on in input lockout");
  thermal_off_a: assert property (sense_in.over_temp [*6] |-> !pwr_out.high_on && !pwr_out.low_on)
    else $error("switch on in over-temperature");
  curr_lim_a: assert property (sense_in.curr_limit [*6] |-> !pwr_out.high_on)
    else $error("high side on at current limit");
  short_pg_a: assert property (sense_in.out_below_04 [*6] |-> !pwr_out.power_good && (pwr_out.half_limit || !pwr_out.control_on))
    else $error("short output without half limit");
  disch_off_a: assert property (pwr_out.discharge_on |-> !pwr_out.control_on && !pwr_out.high_on)
    else $error("discharge while converter on");
endmodule // bdc_ctrl_asserts
bind bdc_ctrl bdc_ctrl_asserts #(.SS_CYC(SS_CYC)) u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .enable_pin_in(enable_pin_in), .sense_in(sense_in),
  .pwr_out(pwr_out));
`default_nettype wire

/* File: bench/bdc_host.sv */
// Processor model: single-word AHB-Lite master and select pin driver.
// Assumes hready is the slave's hreadyout; every change follows a rising edge.
`timescale 1ns/10ps
`default_nettype none
module bdc_host (
  input  wire logic        clk_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_in,
  output var  logic        hsel_out,
  output var  logic [31:0] haddr_out,
  output var  logic [1:0]  htrans_out,
  output var  logic        hwrite_out,
  output var  logic [2:0]  hsize_out,
  output var  logic [31:0] hwdata_out,
  output var  logic        voltage_select_pin_out
);
  initial
  begin
    hsel_out = 1'b0;
    haddr_out = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h0;
    voltage_select_pin_out = 1'b0;
  end
  // Programs floor, roof and slew at any time; stale write data is inverted.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    hsel_out <= 1'b1;
    htrans_out <= 2'h2;
    haddr_out <= {24'h0, a};
    hwrite_out <= w;
    hsize_out <= 3'h2;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    hwdata_out <= d;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    q = hrdata_in;
    hwdata_out <= ~d;
  endtask
  task automatic set_sel(input logic v);
    @(posedge clk_in);
    voltage_select_pin_out <= v;
  endtask
endmodule // bdc_host
`default_nettype wire

/* File: bench/buck_dvs_enable_control_test.sv */
// Self-checking bench for the converter supervisory control.
// Assumes the shortened soft-start count below and a 10 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module buck_dvs_enable_control_test;
  import bdc_pkg::*;
  localparam int SS = 20;
  logic        ref_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        en = 1'b0;
  bdc_sense_t  sense = '0;
  logic        hsel, hwrite, hready, hresp, sel;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [5:0]  vout;
  bdc_pwr_t    pwr;
  int          fails = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          n;
  always #50 ref_clk_in = ~ref_clk_in;
  bdc_ctrl #(.SS_CYC(SS)) DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .enable_pin_in(en),
    .voltage_select_pin_in(sel), .sense_in(sense), .pwr_out(pwr), .vout_code_out(vout));
  bdc_host host (.clk_in(ref_clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr),
    .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata), .voltage_select_pin_out(sel));
  task automatic w(input int c);
    repeat (c) @(posedge ref_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    host.xfer(1'b0, a, 32'h0, q);
    `CHK(nm, {24'h0, e}, q)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h0, d}, q);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic t_start();
    rd(8'h00, 8'hc0, "floor default");
    rd(8'h08, 8'h00, "mode default");
    rd(8'h0c, 8'h07, "ramp default");
    rd(8'h1c, 8'h00, "unmapped");
    sense.out_above_05 <= 1'b1;
    en <= 1'b1;
    for (n = 0; n < 30 && pwr.control_on !== 1'b1; n++) w(1);
    w(1);
    `CHK("widen", 1'b1, pwr.widen_ontime)
    for (n = 0; n < 60 && pwr.widen_ontime !== 1'b0; n++) w(1);
    `CHK("phase one long", 1'b1, n >= SS - 4)
    `CHK("half limit", 1'b1, pwr.half_limit)
    wr(8'h00, 8'hc5);
    rd(8'h04, 8'hc0, "roof kept");
    for (n = 0; n < 60 && pwr.half_limit !== 1'b0; n++) w(1);
    host.xfer(1'b0, 8'h10, 32'h0, q);
    `CHK("run phase", 3'h3, q[2:0])
    sense.at_target <= 1'b1;
    sense.pulsing <= 1'b1;
    w(8);
    `CHK("floor level", 6'h05, vout)
    $display("start test done");
  endtask
  task automatic t_select();
    wr(8'h04, 8'hca);
    w(8);
    `CHK("unselected write", 6'h05, vout)
    wr(8'h08, 8'h02);
    host.set_sel(1'b1);
    w(8);
    `CHK("roof level", 6'h0a, vout)
    `CHK("roof forced pwm", 1'b0, pwr.pfm_mode)
    sense.pulsing <= 1'b0;
    host.set_sel(1'b0);
    for (n = 0; n < 10 && pwr.stop_switching !== 1'b1; n++) w(1);
    `CHK("stop switching", 1'b1, pwr.stop_switching)
    w(8);
    `CHK("floor step down", 6'h05, vout)
    `CHK("floor auto mode", 1'b1, pwr.pfm_mode)
    `CHK("pg held", 1'b0, pwr.power_good)
    sense.pulsing <= 1'b1;
    w(8);
    `CHK("pg back", 1'b1, pwr.power_good)
    wr(8'h00, 8'hc3);
    w(8);
    `CHK("selected write", 6'h03, vout)
    $display("select test done");
  endtask
  task automatic t_slew();
    logic [5:0] t;
    for (int s = 0; s < 7; s++)
    begin
      t = (s % 2 == 0) ? 6'h09 : 6'h03;
      wr(8'h0c, 8'(s));
      wr(8'h00, {2'b11, t});
      w(4);
      `CHK("micro step pending", 1'b0, vout == t)
      `CHK("pg while ramping", 1'b0, pwr.power_good)
      w((16 << s) * 7 + 10);
      `CHK("micro step done", t, vout)
    end
    $display("slew test done");
  endtask
  task automatic t_prot();
    sense.vin_low <= 1'b1;
    w(6);
    `CHK("lockout", 2'b00, {pwr.high_on, pwr.low_on})
    sense.vin_low <= 1'b0;
    sense.over_temp <= 1'b1;
    w(6);
    `CHK("thermal", 2'b00, {pwr.high_on, pwr.low_on})
    sense.over_temp <= 1'b0;
    w(10);
    `CHK("thermal resume", 1'b1, pwr.high_on)
    sense.curr_limit <= 1'b1;
    w(6);
    `CHK("current limit", 2'b01, {pwr.high_on, pwr.low_on})
    sense.curr_limit <= 1'b0;
    sense.out_below_04 <= 1'b1;
    w(6);
    `CHK("short", 2'b01, {pwr.power_good, pwr.half_limit})
    sense.out_below_04 <= 1'b0;
    $display("protection test done");
  endtask
  task automatic t_off();
    wr(8'h0c, 8'h47);
    wr(8'h00, 8'h83);
    w(6);
    `CHK("soft off", 4'b0010, {pwr.control_on, pwr.divider_on, pwr.discharge_on, pwr.high_on})
    rd(8'h00, 8'h83, "bus in soft off");
    en <= 1'b0;
    w(6);
    wr(8'h00, 8'h55);
    rd(8'h00, 8'h83, "write refused");
    en <= 1'b1;
    w(8);
    rd(8'h00, 8'hc0, "floor reload");
    rd(8'h0c, 8'h07, "ramp reload");
    $display("shutdown test done");
  endtask
  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails++;
      results();
    end
  end
  initial
  begin
    w(2);
    rst_in <= 1'b0;
    t_start();
    t_select();
    t_slew();
    t_prot();
    t_off();
    results();
  end
endmodule // buck_dvs_enable_control_test
`default_nettype wire
